/* File: design/drive_command_status_interface.sv */
// drive command interpreter, device naming, indicators and factory reset with apb registers
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps

// Operation
// - nonzero switches at power-on form name
// - zero switches use nonzero stored address
// - both zero: use controller-assigned name
// - delivery state: all zero, name empty
// - port leds: link, activity flicker 10 Hz
// - bus fault led off, 2 Hz, on
// - status fault: identify flash 3 s, faults on
// - motor led by supply, flash if delivery
// - 0x14 starts positioning, 0x00 aborts
// - new target redirects running positioning
// - manual command aborts positioning, runs manual
// - target staged, run starts on release
// - loop run configured by loop register
// - acyclic command writes only pre-operational
// - 0x11/0x12 manual; 0x10 or 0x00 ends
// - target during manual ends manual run
// - switches 98: flash 10 s, 99 restores
// - bus communication ends reset window early
// - images are 14 and 16 bytes
// - acyclic write ignored when control byte zero
// - acyclic write 3 or 5 bytes
// - 16-bit status word, bit 0 reached
module drive_command_status_interface
#(
  parameter int ident_cycles  = drive_cmd_pkg::ident_cyc,
  parameter int fr_win_cycles = drive_cmd_pkg::fr_window_cyc,
  parameter int bf_half       = drive_cmd_pkg::bf_half_cyc,
  parameter int act_half      = drive_cmd_pkg::act_half_cyc
)
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic [7:0]                paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      switch_present,
  input  wire logic [7:0]                switch_value,
  input  wire logic                      pre_operational,
  input  wire logic                      cyc_ctrl_valid,
  input  wire logic [7:0]                cyc_ctrl_word,
  input  wire logic [31:0]               cyc_target,
  input  wire drive_cmd_pkg::drive_fb_t  drive_fb,
  output drive_cmd_pkg::drive_cmd_t      drive_cmd,
  output drive_cmd_pkg::leds_t           leds,
  output logic [15:0]                    status_word
);
  import drive_cmd_pkg::*;

  // whole module state
  typedef struct packed
  {
    logic [1:0]  sw_sync1;
    logic [1:0]  sw_sync2;
    logic [7:0]  swv_sync1;
    logic [7:0]  swv_sync2;
    logic        strapped;
    logic [1:0]  strap_cnt;
    logic [7:0]  power_sw;
    logic [15:0] stored_adr;
    logic [7:0]  cond;
    logic [7:0]  ctrl;
    logic [31:0] target;
    logic        target_new;
    logic [15:0] loop_cfg;
    run_state_t  run;
    logic        man_rev;
    fr_state_t   fr;
    logic [31:0] fr_cnt;
    logic        load_defaults;
    logic        delivery;
    logic [31:0] ident_cnt;
    logic [31:0] bf_cnt;
    logic        bf_blink;
    logic [31:0] act_cnt;
    logic        act_blink;
    logic [31:0] fr_blk_cnt;
    logic        fr_blink;
    logic [31:0] acyc_val;
    logic [2:0]  acyc_len;
    logic [31:0] prdata;
    leds_t       leds;
    drive_cmd_t  cmd;
    logic [15:0] status;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // cond bits: 0 link0, 1 traffic0, 2 link1, 3 traffic1, 4 bus connected,
  // 5 data exchange, 6 fault/watchdog/diag, 7 motor supply in range
  logic        acc;
  logic        wr;
  logic        cmd_en;
  logic [7:0]  cw;
  logic [31:0] tgt;
  logic [31:0] fr_half;
  name_src_t   nsrc;
  logic [15:0] name_adr;

  always_comb
  begin
    s_next   = s_reg;
    acc      = psel && penable;
    wr       = acc && pwrite;
    fr_half  = fr_win_cycles / (2 * fr_window_sec * fr_flash_hz);
    cmd_en   = 1'b0;
    cw       = s_reg.ctrl;
    tgt      = s_reg.target;
    nsrc     = name_from_assigned;
    name_adr = 16'h0000;

    // two-flop synchronisers for pin inputs
    s_next.sw_sync1  = {switch_present, 1'b0};
    s_next.sw_sync2  = s_reg.sw_sync1;
    s_next.swv_sync1 = switch_value;
    s_next.swv_sync2 = s_reg.swv_sync1;

    // capture switch value once the synchroniser chain holds the pins (3rd edge after reset)
    if (!s_reg.strapped && s_reg.strap_cnt != 2'd2)
      s_next.strap_cnt = s_reg.strap_cnt + 2'd1;
    else if (!s_reg.strapped)
    begin
      s_next.strapped = 1'b1;
      s_next.power_sw = s_reg.sw_sync2[1] ? s_reg.swv_sync2 : sw_zero;
      if (s_reg.sw_sync2[1] && s_reg.swv_sync2 == sw_reset_arm)
      begin
        s_next.fr     = fr_wait;
        s_next.fr_cnt = 32'h0;
      end
    end

    // name source selection
    if (s_reg.power_sw != sw_zero)
    begin
      nsrc     = name_from_switch;
      name_adr = {8'h00, s_reg.power_sw};
    end
    else if (s_reg.stored_adr != 16'h0000)
    begin
      nsrc     = name_from_stored;
      name_adr = s_reg.stored_adr;
    end
    else
    begin
      nsrc = name_from_assigned;
    end

    // command sources: cyclic image, or registers while pre-operational
    if (cyc_ctrl_valid)
    begin
      cmd_en = 1'b1;
      cw     = cyc_ctrl_word;
      tgt    = cyc_target;
    end
    s_next.target_new = 1'b0;
    s_next.load_defaults = 1'b0;

    // apb writes
    if (wr)
    begin
      case (paddr)
        off_stored_adr: s_next.stored_adr = pwdata[15:0];
        off_cond:       s_next.cond       = pwdata[7:0];
        off_loop_cfg:   s_next.loop_cfg   = pwdata[15:0];
        off_ctrl_word:
          if (pre_operational)
          begin
            cmd_en = 1'b1;
            cw     = pwdata[7:0];
            tgt    = s_reg.target;
          end
        off_target:
          if (pre_operational)
            s_next.target = pwdata;
        off_acyc_wr:
          // byte 3 is the control byte, [23:21] length, [20:0] value
          if (pwdata[31:24] != 8'h00)
          begin
            s_next.acyc_len = (pwdata[23:21] == acyc_wr_len32) ? acyc_rd_len32 : acyc_rd_len16;
            s_next.acyc_val = {11'h000, pwdata[20:0]};
          end
        default: ;
      endcase
    end

    // control word interpretation
    if (cmd_en)
    begin
      s_next.ctrl = cw;
      if (cw[cw_xfer])
      begin
        s_next.target     = tgt;
        s_next.target_new = 1'b1;
      end
      if (!cw[cw_release])
        s_next.run = run_idle;
      else if (cw[cw_man_fwd] ^ cw[cw_man_rev])
      begin
        s_next.run     = run_man;
        s_next.man_rev = cw[cw_man_rev];
      end
      else if (cw[cw_xfer] || (!s_reg.ctrl[cw_release] && s_reg.run == run_idle))
        s_next.run = run_pos;
      else if (s_reg.run == run_man)
        s_next.run = run_idle;
    end
    else if (s_reg.run == run_pos && drive_fb.target_reached)
      s_next.run = run_idle;

    // factory reset window
    case (s_reg.fr)
      fr_off:  ;
      fr_wait:
      begin
        s_next.fr_cnt = s_reg.fr_cnt + 32'h1;
        if (s_reg.fr_cnt >= fr_half - 32'h1 && s_reg.fr_blk_cnt >= fr_half - 32'h1)
          s_next.fr_blk_cnt = 32'h0;
        s_next.fr_blk_cnt = (s_reg.fr_blk_cnt >= fr_half - 32'h1) ? 32'h0 : s_reg.fr_blk_cnt + 32'h1;
        if (s_reg.fr_blk_cnt >= fr_half - 32'h1)
          s_next.fr_blink = ~s_reg.fr_blink;
        if (s_reg.swv_sync2 == sw_reset_go)
        begin
          s_next.fr            = fr_done;
          s_next.load_defaults = 1'b1;
          s_next.stored_adr    = stored_adr_rst;
          s_next.loop_cfg      = loop_rst;
          s_next.target        = 32'h8000_0000;
          s_next.run           = run_pos;
        end
        else if (s_reg.cond[5] || s_reg.fr_cnt >= fr_win_cycles - 1)
          s_next.fr = fr_done;
      end
      fr_done: ;
      default: s_next.fr = fr_off;
    endcase

    // delivery state tracking
    s_next.delivery = (s_next.stored_adr == 16'h0000) && (s_reg.power_sw == sw_zero);

    // identify flash window
    if (wr && paddr == off_status && pwdata[0])
      s_next.ident_cnt = ident_cycles;
    else if (s_reg.ident_cnt != 32'h0)
      s_next.ident_cnt = s_reg.ident_cnt - 32'h1;

    // blink generators
    s_next.bf_cnt  = (s_reg.bf_cnt >= bf_half - 1) ? 32'h0 : s_reg.bf_cnt + 32'h1;
    if (s_reg.bf_cnt >= bf_half - 1)
      s_next.bf_blink = ~s_reg.bf_blink;
    s_next.act_cnt = (s_reg.act_cnt >= act_half - 1) ? 32'h0 : s_reg.act_cnt + 32'h1;
    if (s_reg.act_cnt >= act_half - 1)
      s_next.act_blink = ~s_reg.act_blink;

    // indicators
    for (int p = 0; p < 2; p++)
    begin
      s_next.leds.link_led[p] = s_reg.cond[2*p];
      s_next.leds.act_led[p]  = s_reg.cond[2*p] && s_reg.cond[2*p+1] && s_reg.act_blink;
    end
    if (s_reg.cond[5])
      s_next.leds.bus_fault_indicator = 1'b0;
    else if (s_reg.cond[4])
      s_next.leds.bus_fault_indicator = s_reg.bf_blink;
    else
      s_next.leds.bus_fault_indicator = 1'b1;
    if (s_reg.cond[6])
      s_next.leds.status_fault_indicator = 1'b1;
    else
      s_next.leds.status_fault_indicator = (s_reg.ident_cnt != 32'h0) && s_reg.bf_blink;
    if (s_reg.fr == fr_wait)
      s_next.leds.motor_led = s_reg.fr_blink;
    else if (!s_reg.cond[7])
      s_next.leds.motor_led = 1'b0;
    else
      s_next.leds.motor_led = s_reg.delivery ? s_reg.bf_blink : 1'b1;

    // drive command outputs
    s_next.cmd.pos_run       = (s_next.run == run_pos);
    s_next.cmd.man_run       = (s_next.run == run_man);
    s_next.cmd.man_dir_rev   = s_next.man_rev;
    s_next.cmd.target        = s_next.target;
    s_next.cmd.retarget      = s_next.target_new && (s_next.run == run_pos);
    s_next.cmd.loop_cfg      = s_reg.loop_cfg;
    s_next.cmd.load_defaults = s_next.load_defaults;

    // status word
    s_next.status = {drive_fb.flags, drive_fb.target_reached};

    // apb read data
    s_next.prdata = 32'h0;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        off_name_src:   s_next.prdata = {14'h0, nsrc, name_adr};
        off_stored_adr: s_next.prdata = {16'h0, s_reg.stored_adr};
        off_cond:       s_next.prdata = {24'h0, s_reg.cond};
        off_ctrl_word:  s_next.prdata = {24'h0, s_reg.ctrl};
        off_target:     s_next.prdata = s_reg.target;
        off_status:     s_next.prdata = {10'h0, s_reg.fr, s_reg.run, s_reg.status};
        off_loop_cfg:   s_next.prdata = {16'h0, s_reg.loop_cfg};
        off_leds:       s_next.prdata = {25'h0, s_reg.leds};
        off_acyc_par:   s_next.prdata = {s_reg.acyc_len, 5'h0, s_reg.acyc_val[23:0]};
        off_img_size:   s_next.prdata = {16'h0, in_img_bytes, out_img_bytes};
        default:        s_next.prdata = 32'h0;
      endcase
    end
  end

  // state register with clock enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg            <= '0;
      s_reg.stored_adr <= stored_adr_rst;
      s_reg.ctrl       <= ctrl_rst;
      s_reg.target     <= target_rst;
      s_reg.loop_cfg   <= loop_rst;
      s_reg.run        <= run_idle;
      s_reg.fr         <= fr_off;
      s_reg.leds       <= '0;
      s_reg.leds.bus_fault_indicator <= 1'b1;
    end
    else if (clk_en)
      s_reg <= s_next;
  end

  // outputs
  assign prdata      = s_reg.prdata;
  assign pready      = 1'b1;
  assign pslverr     = 1'b0;
  assign drive_cmd   = s_reg.cmd;
  assign leds        = s_reg.leds;
  assign status_word = s_reg.status;

endmodule

/* File: design/drive_cmd_pkg.sv */
// package with constants, types and register map for the drive command and status block
package drive_cmd_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] off_name_src   = 8'h00; // ro: name source and resolved address
  localparam logic [7:0] off_stored_adr = 8'h04; // rw: stored device address
  localparam logic [7:0] off_cond       = 8'h08; // rw: link/bus/fault/power conditions
  localparam logic [7:0] off_ctrl_word  = 8'h0c; // rw: control word (acyclic path)
  localparam logic [7:0] off_target     = 8'h10; // rw: target value (acyclic path)
  localparam logic [7:0] off_status     = 8'h14; // rw: status word and run state on read; writing bit 0 starts identify flash
  localparam logic [7:0] off_loop_cfg   = 8'h18; // rw: loop run configuration
  localparam logic [7:0] off_leds       = 8'h1c; // ro: indicator outputs
  localparam logic [7:0] off_acyc_wr    = 8'h20; // wo: acyclic write frame
  localparam logic [7:0] off_acyc_par   = 8'h24; // ro: last executed acyclic value
  localparam logic [7:0] off_img_size   = 8'h28; // ro: process image sizes

  // reset values
  localparam logic [15:0] stored_adr_rst = 16'h0000;
  localparam logic [31:0] target_rst     = 32'h0000_0000;
  localparam logic [7:0]  ctrl_rst       = 8'h00;
  localparam logic [15:0] loop_rst       = 16'h0000;

  // control word bit positions
  localparam int cw_man_fwd = 0;
  localparam int cw_man_rev = 1;
  localparam int cw_xfer    = 2;
  localparam int cw_release = 4;

  // switch codes
  localparam logic [7:0] sw_zero      = 8'h00;
  localparam logic [7:0] sw_reset_arm = 8'd98;
  localparam logic [7:0] sw_reset_go  = 8'd99;

  // process image sizes in bytes
  localparam logic [7:0] out_img_bytes = 8'd14;
  localparam logic [7:0] in_img_bytes  = 8'd16;

  // acyclic frame lengths
  localparam logic [2:0] acyc_wr_len16 = 3'd3;
  localparam logic [2:0] acyc_wr_len32 = 3'd5;
  localparam logic [2:0] acyc_rd_len16 = 3'd2;
  localparam logic [2:0] acyc_rd_len32 = 3'd4;

  // timing
  localparam int clk_hz        = 40_000_000;
  localparam int act_flick_hz  = 10;
  localparam int bf_flash_hz   = 2;
  localparam int ident_sec     = 3;
  localparam int fr_flash_hz   = 10;
  localparam int fr_window_sec = 10;
  localparam int act_half_cyc  = clk_hz / (2 * act_flick_hz);
  localparam int bf_half_cyc   = clk_hz / (2 * bf_flash_hz);
  localparam int ident_cyc     = clk_hz * ident_sec;
  localparam int fr_window_cyc = clk_hz * fr_window_sec;

  // name source encoding
  typedef enum logic [1:0]
  {
    name_from_switch   = 2'b01,
    name_from_stored   = 2'b10,
    name_from_assigned = 2'b00
  } name_src_t;

  // run states, one-hot
  typedef enum logic [2:0]
  {
    run_idle = 3'b001,
    run_pos  = 3'b010,
    run_man  = 3'b100
  } run_state_t;

  // factory reset states, one-hot
  typedef enum logic [2:0]
  {
    fr_off  = 3'b001,
    fr_wait = 3'b010,
    fr_done = 3'b100
  } fr_state_t;

  // per port link conditions
  typedef struct packed
  {
    logic link;
    logic traffic;
  } port_cond_t;

  // indicator outputs
  typedef struct packed
  {
    logic [1:0] link_led;
    logic [1:0] act_led;
    logic       bus_fault_indicator;
    logic       status_fault_indicator;
    logic       motor_led;
  } leds_t;

  // drive command towards motion control
  typedef struct packed
  {
    logic        pos_run;
    logic        man_run;
    logic        man_dir_rev;
    logic [31:0] target;
    logic        retarget;
    logic [15:0] loop_cfg;
    logic        load_defaults;
  } drive_cmd_t;

  // feedback from motion control
  typedef struct packed
  {
    logic        target_reached;
    logic [14:0] flags;
  } drive_fb_t;

endpackage

/* File: verif/drive_cmd_sva.sv */
// port checker for the drive command and status block
`timescale 1ns/10ps
module drive_cmd_chk
  import drive_cmd_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cyc_ctrl_valid,
  input wire logic [7:0]  cyc_ctrl_word,
  input wire logic [31:0] cyc_target,
  input wire drive_fb_t   drive_fb,
  input wire drive_cmd_t  drive_cmd,
  input wire leds_t       leds,
  input wire logic [15:0] status_word
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // cyclic frame with a given control word taken at this edge
  sequence s_cyc(logic [7:0] w);
    cyc_ctrl_valid && clk_en && cyc_ctrl_word == w;
  endsequence

  // properties check apb answer, status word, activity leds and the command outputs caused by frames with control words 0x14, 0x00, 0x11, 0x12 and 0x10
  property p_zero_wait;
    pready && !pslverr;
  endproperty
  property p_pos_start;
    s_cyc(8'h14) |=> drive_cmd.pos_run && !drive_cmd.man_run && drive_cmd.target == $past(cyc_target);
  endproperty
  property p_abort;
    s_cyc(8'h00) |=> !drive_cmd.pos_run && !drive_cmd.man_run;
  endproperty
  property p_man_fwd;
    s_cyc(8'h11) |=> drive_cmd.man_run && !drive_cmd.man_dir_rev;
  endproperty
  property p_man_rev;
    s_cyc(8'h12) |=> drive_cmd.man_run && drive_cmd.man_dir_rev;
  endproperty
  property p_pos_to_man;
    s_cyc(8'h11) ##0 drive_cmd.pos_run |=> (!drive_cmd.pos_run && drive_cmd.man_run) [*2];
  endproperty
  property p_man_end;
    s_cyc(8'h10) ##0 drive_cmd.man_run |=> !drive_cmd.man_run && !drive_cmd.pos_run;
  endproperty
  property p_man_to_pos;
    s_cyc(8'h14) ##0 drive_cmd.man_run |=> drive_cmd.pos_run && !drive_cmd.man_run;
  endproperty
  property p_status;
    $past(presetn) && $past(clk_en) |-> status_word == {$past(drive_fb.flags), $past(drive_fb.target_reached)};
  endproperty
  property p_act_link;
    (leds.act_led & ~leds.link_led) == 2'b00;
  endproperty

  a_zero_wait: assert property (p_zero_wait) else $error("apb answer not zero wait");
  a_pos_start: assert property (p_pos_start) else $error("positioning not started");
  a_abort: assert property (p_abort) else $error("run not aborted");
  a_man_fwd: assert property (p_man_fwd) else $error("forward manual run wrong");
  a_man_rev: assert property (p_man_rev) else $error("reverse manual run wrong");
  a_pos_to_man: assert property (p_pos_to_man) else $error("manual did not replace positioning");
  a_man_end: assert property (p_man_end) else $error("manual run not ended");
  a_man_to_pos: assert property (p_man_to_pos) else $error("target did not end manual run");
  a_status: assert property (p_status) else $error("status word wrong");
  a_act_link: assert property (p_act_link) else $error("activity without link");
endmodule

bind drive_command_status_interface drive_cmd_chk chk_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .pready(pready), .pslverr(pslverr), .cyc_ctrl_valid(cyc_ctrl_valid), .cyc_ctrl_word(cyc_ctrl_word),
  .cyc_target(cyc_target), .drive_fb(drive_fb), .drive_cmd(drive_cmd), .leds(leds), .status_word(status_word));

/* File: verif/io_ctrl_model.sv */
// model of the io controller sending cyclic command frames
`timescale 1ns/10ps
module io_ctrl_model
(
  input  wire logic   pclk,
  output logic        cyc_ctrl_valid,
  output logic [7:0]  cyc_ctrl_word,
  output logic [31:0] cyc_target
);
  initial
  begin
    cyc_ctrl_valid = 1'b0;
    cyc_ctrl_word  = 8'h00;
    cyc_target     = 32'h0;
  end

  // one frame of control word and target; lines show the inverse between frames
  task automatic send(input logic [7:0] w, input logic [31:0] t);
    @(posedge pclk);
    cyc_ctrl_valid <= 1'b1;
    cyc_ctrl_word  <= w;
    cyc_target     <= t;
    @(posedge pclk);
    cyc_ctrl_valid <= 1'b0;
    cyc_ctrl_word  <= ~w;
    cyc_target     <= ~t;
  endtask
endmodule

/* File: verif/tb_drive_command_status_interface.sv */
// self-checking bench for the drive command and status block
`timescale 1ns/10ps
module tb_drive_command_status_interface;
  import drive_cmd_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sw_on = 1'b1;
  logic [7:0]  sw_val = 8'h05;
  logic        pre_op = 1'b0;
  logic        ce = 1'b1;
  logic        cv;
  logic [7:0]  cw;
  logic [31:0] ct;
  drive_fb_t   fb = '0;
  drive_cmd_t  cmd;
  leds_t       leds;
  logic [6:0]  lv;
  logic [15:0] status_word;
  logic [31:0] q;
  int          err_total = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          t;
  logic [7:0]  cws [10] = '{8'h14, 8'h14, 8'h11, 8'h12, 8'h10, 8'h11, 8'h14, 8'h00, 8'h04, 8'h10};
  logic [31:0] tvs [10] = '{32'd100, 32'd200, 0, 0, 0, 0, 32'd300, 0, 32'd400, 0};
  logic [1:0]  pms [10] = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b00, 2'b01, 2'b10, 2'b00, 2'b00, 2'b10};

  assign lv = leds;
  always #12.5 pclk = ~pclk;

  drive_command_status_interface #(.ident_cycles(40), .fr_win_cycles(400), .bf_half(5), .act_half(3)) dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_present(sw_on), .switch_value(sw_val), .pre_operational(pre_op), .cyc_ctrl_valid(cv),
    .cyc_ctrl_word(cw), .cyc_target(ct), .drive_fb(fb), .drive_cmd(cmd), .leds(leds), .status_word(status_word));

  io_ctrl_model pm_u (.pclk(pclk), .cyc_ctrl_valid(cv), .cyc_ctrl_word(cw), .cyc_target(ct));

  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts changes of one indicator bit over n cycles
  task automatic tog(input int b, input int n, output int c);
    logic p;
    c = 0;
    @(posedge pclk);
    p = lv[b];
    repeat (n)
    begin
      @(posedge pclk);
      if (lv[b] !== p)
        c++;
      p = lv[b];
    end
  endtask

  task automatic rst(input logic [7:0] s);
    @(posedge pclk);
    presetn <= 1'b0;
    sw_val <= s;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask

  // hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst(8'h05);
    chk("leds_rst", 32'(lv), 32'h04);
    apb(1'b0, off_name_src, 0);
    chk("name_sw", 32'(q[17:0]), 32'h1_0005);
    apb(1'b0, off_img_size, 0);
    chk("img", 32'(q[15:0]), 32'h100e);
    apb(1'b0, 8'h3c, 0);
    chk("unmapped", q, 0);
    rst(8'h00);
    apb(1'b0, off_name_src, 0);
    chk("name_asg", 32'(q[17:0]), 0);
    apb(1'b0, off_stored_adr, 0);
    chk("stored", q, 0);
    apb(1'b1, off_cond, 32'h10);
    tog(2, 30, t);
    chk("bf_flash", 32'(t inside {[5:7]}), 1);
    apb(1'b1, off_cond, 32'hb3);
    tog(3, 30, t);
    chk("act_flick", 32'(t inside {[9:11]}), 1);
    chk("ports", 32'({lv[6:4], lv[2]}), 32'h4);
    fb <= '{1'b1, 15'h2a5a};
    repeat (2) @(posedge pclk);
    chk("status", 32'(status_word), 32'h54b5);
    apb(1'b1, off_status, 1);
    tog(1, 60, t);
    chk("sf_ident", 32'({t inside {[6:9]}, lv[1]}), 32'h2);
    apb(1'b1, off_cond, 32'hf3);
    repeat (3) @(posedge pclk);
    chk("sf_fault", 32'(lv[1]), 1);
    // clock enable low must freeze the flickering activity led
    ce <= 1'b0;
    @(posedge pclk);
    q = 32'(lv);
    repeat (12) @(posedge pclk);
    chk("freeze", 32'(lv), q);
    ce <= 1'b1;
    fb <= '0;
    for (int i = 0; i < 10; i++)
    begin
      pm_u.send(cws[i], tvs[i]);
      repeat (2) @(posedge pclk);
      chk("run", 32'({cmd.pos_run, cmd.man_run}), 32'(pms[i]));
      if (pms[i][1])
        chk("target", cmd.target, tvs[i == 9 ? 8 : i]);
      if (pms[i][0])
        chk("dir", 32'(cmd.man_dir_rev), 32'(cws[i][1]));
    end
    pm_u.send(8'h00, 0);
    repeat (2) @(posedge pclk);
    for (int k = 0; k < 2; k++)
    begin
      pre_op <= k[0];
      apb(1'b1, off_target, 32'h55);
      apb(1'b1, off_ctrl_word, 32'h14);
      repeat (2) @(posedge pclk);
      chk("sdo_run", 32'({cmd.pos_run, cmd.target == 32'h55}), k ? 32'h3 : 32'h0);
    end
    apb(1'b1, off_ctrl_word, 0);
    pre_op <= 1'b0;
    apb(1'b1, off_acyc_wr, {8'h01, acyc_wr_len16, 21'h123});
    apb(1'b0, off_acyc_par, 0);
    chk("acyc16", 32'(q[31:29]), 32'(acyc_rd_len16));
    chk("acyc16_val", 32'(q[20:0]), 32'h123);
    apb(1'b1, off_acyc_wr, {8'h00, acyc_wr_len32, 21'h456});
    apb(1'b0, off_acyc_par, 0);
    chk("acyc_skip", 32'(q[31:29]), 32'(acyc_rd_len16));
    chk("acyc_skip_val", 32'(q[20:0]), 32'h123);
    apb(1'b1, off_acyc_wr, {8'h02, acyc_wr_len32, 21'h789});
    apb(1'b0, off_acyc_par, 0);
    chk("acyc32", 32'(q[31:29]), 32'(acyc_rd_len32));
    chk("acyc32_val", 32'(q[20:0]), 32'h789);
    rst(sw_reset_arm);
    apb(1'b0, off_status, 0);
    chk("fr_wait", 32'(q[21:19]), 32'(fr_wait));
    sw_val <= sw_reset_go;
    t = 0;
    while (cmd.pos_run !== 1'b1 && t < 60)
    begin
      @(posedge pclk);
      t++;
    end
    chk("fr_mid", cmd.target, 32'h8000_0000);
    tally_and_finish();
  end
endmodule
